// ===== include/dss_pkg.sv
/*
  Package of the deep sleep entry sequencer: instruction codes, revision
  codes, register and field positions, and entry timing.
  Assumes the processor core reports each retired instruction with a code.
*/
package dss_pkg;
  // Instruction classes reported by the core, one per instruction cycle
  typedef enum logic [1:0] {
    DSS_OP_OTHER = 2'h0,
    DSS_OP_NOP = 2'h1,
    DSS_OP_ARM = 2'h2,
    DSS_OP_SLEEP = 2'h3
  } dss_op_type;

  // Sequencer states
  typedef enum logic [2:0] {
    DSS_RUN,
    DSS_ENTRY,
    DSS_SLEEP,
    DSS_DEEP
  } dss_state_type;

  // Silicon revision codes, values arbitrary
  localparam logic [4:0] DSS_REV_EARLY = 5'h0_002;
  localparam logic [4:0] DSS_REV_LATE = 5'h0_004;

  // Control register field position and reset value
  localparam int DSS_ARM_BIT = 7;
  localparam logic [7:0] DSS_CTRL_RESET = 8'h00;

  // Configuration address of the revision word
  localparam logic [21:0] DSS_REVID_ADDR = 22'h3F_FFFE;

  // Entry period: 2 instruction cycles of 10 ns each
  localparam int DSS_ENTRY_NS = 20;
  localparam int DSS_CLK_NS = 10;
  localparam logic [1:0] DSS_ENTRY_CYC = 2'((DSS_ENTRY_NS + DSS_CLK_NS - 1) / DSS_CLK_NS);
  localparam logic [1:0] DSS_CNT_ZERO = 2'h0;
  localparam logic [1:0] DSS_CNT_ONE = 2'h1;
endpackage

// ===== hw/dss_entry_timer.sv
/*
  Down counter for the deep sleep entry period.
  Assumes a single clock and a start pulse from the sequencer.
*/
`timescale 1ns/1ps
module dss_entry_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic last
);
  import dss_pkg::*;
  logic [1:0] count;
  logic [1:0] next_count;

  // Load on start, count to zero
  always_comb begin
    next_count = count;
    if (start) begin
      next_count = DSS_ENTRY_CYC;
    end else if (count != DSS_CNT_ZERO) begin
      next_count = count - DSS_CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= DSS_CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != DSS_CNT_ZERO);
  assign last = (count == DSS_CNT_ONE);
endmodule // dss_entry_timer

// ===== hw/dss_sequencer.sv
/*
  Deep sleep entry sequencer: decides between conventional Sleep and Deep
  Sleep on each sleep instruction, runs the entry period, and handles wake.
  Assumes the core reports one instruction per clock (one instruction cycle)
  with a valid strobe, and that wake sources are synchronous levels/pulses.
*/
// Functional notes
// - Deep Sleep entry takes two instruction cycles after the sleep instruction.
// - Wake events arriving inside the entry period may be dropped.
// - Arm bit is bit 7 of control high register; selects Deep Sleep.
// - Later revision accepts at most one instruction between arming and sleep.
// - Later revision with one nop between arm and sleep loses no wakes.
// - Earlier revision: any instruction between arm and sleep gives conventional Sleep.
// - Later revision, sleep right after arm: Deep Sleep, lossy window kept.
// - Revision identifier readable through table read at configuration address.
`timescale 1ns/1ps
module dss_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic late_rev,
  input wire logic op_valid,
  input wire dss_pkg::dss_op_type op_code,
  input wire logic [7:0] ctrl_wdata,
  input wire logic table_rd,
  input wire logic [21:0] table_addr,
  input wire logic wake_event,
  output logic [7:0] ctrl_high,
  output logic [7:0] table_data,
  output logic core_halt,
  output logic in_sleep,
  output logic in_deep_sleep,
  output logic wake_resume,
  output logic wake_lost
);
  import dss_pkg::*;

  // Sequencer state. The core is stalled in every state but DSS_RUN, so any
  // instruction reported while in DSS_RUN counts as retired and is acted on.
  // Instructions reported while halted are ignored: a stalled core retires none.
  dss_state_type state;
  dss_state_type next_state;
  logic [7:0] next_ctrl_high;

  // Instructions retired since the last arming write, saturating at two.
  // Only 0 and 1 matter to the decision; two stands for any longer gap.
  logic [1:0] arm_gap;
  logic [1:0] next_arm_gap;

  // Set when exactly one nop sat between arming and sleep. Only then does the
  // later revision close the lossy entry window, so a plain instruction in the
  // same slot still gives Deep Sleep but without protection of wakes.
  logic guarded;
  logic next_guarded;

  // Next values of the registered outputs
  logic next_core_halt;
  logic next_in_sleep;
  logic next_in_deep;
  logic next_wake_resume;
  logic next_wake_lost;
  logic [7:0] next_table_data;

  // Entry period timer handshake: start is a one-cycle pulse on the sleep
  // that grants Deep Sleep; last marks the final cycle of the entry period.
  logic timer_start;
  logic timer_busy;
  logic timer_last;
  logic deep_ok;

  dss_entry_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(timer_start),
    .busy(timer_busy),
    .last(timer_last)
  );

  // Deep Sleep is granted by the arm bit and by how far the sleep trails the arming write.
  // The earlier revision loses the grant as soon as anything retires in between;
  // firmware that must run on both revisions should issue sleep right after arming.
  always_comb begin
    deep_ok = 1'b0;
    if (ctrl_high[DSS_ARM_BIT]) begin
      if (arm_gap == DSS_CNT_ZERO) begin
        deep_ok = 1'b1;
      end else if (arm_gap == DSS_CNT_ONE) begin
        deep_ok = late_rev;
      end else begin
        deep_ok = 1'b0;
      end
    end
  end

  // Sequencer, arm tracking and wake handling.
  // Wakes are only looked at while halted; a wake level in DSS_RUN is ignored,
  // since the core is running and has nothing to resume from.
  always_comb begin
    next_state = state;
    next_ctrl_high = ctrl_high;
    next_arm_gap = arm_gap;
    next_guarded = guarded;
    next_core_halt = core_halt;
    next_in_sleep = 1'b0;
    next_in_deep = 1'b0;
    next_wake_resume = 1'b0;
    next_wake_lost = 1'b0;
    timer_start = 1'b0;
    unique case (state)
      DSS_RUN: begin
        next_core_halt = 1'b0;
        if (op_valid) begin
          if (op_code == DSS_OP_ARM) begin
            next_ctrl_high = ctrl_wdata;
            next_arm_gap = DSS_CNT_ZERO;
            next_guarded = 1'b0;
          end else if (op_code == DSS_OP_SLEEP) begin
            next_core_halt = 1'b1;
            if (deep_ok) begin
              // A lone nop ahead of sleep on the later revision closes the lossy window
              next_guarded = late_rev && (arm_gap == DSS_CNT_ONE) && guarded;
              next_state = DSS_ENTRY;
              timer_start = 1'b1;
            end else begin
              next_state = DSS_SLEEP;
            end
          end else begin
            // Gap saturates at two: anything longer is treated alike
            if (arm_gap != DSS_ENTRY_CYC) begin
              next_arm_gap = arm_gap + DSS_CNT_ONE;
            end
            next_guarded = (op_code == DSS_OP_NOP) && (arm_gap == DSS_CNT_ZERO);
          end
        end
      end
      DSS_ENTRY: begin
        // Wakes resume the core at once only when guarded; otherwise they vanish here
        if (wake_event && !guarded) begin
          next_wake_lost = 1'b1;
        end
        if (timer_last) begin
          next_state = DSS_DEEP;
          if (wake_event && guarded) begin
            next_state = DSS_RUN;
            next_wake_resume = 1'b1;
            next_core_halt = 1'b0;
          end
        end else if (!timer_busy) begin
          next_state = DSS_DEEP;
        end
        if (guarded && wake_event && !timer_last) begin
          next_guarded = 1'b1;
          next_state = DSS_RUN;
          next_wake_resume = 1'b1;
          next_core_halt = 1'b0;
        end
      end
      DSS_SLEEP, DSS_DEEP: begin
        next_in_sleep = (state == DSS_SLEEP);
        next_in_deep = (state == DSS_DEEP);
        if (wake_event) begin
          // Resume at the instruction after sleep; arm bit drops on deep wake
          next_state = DSS_RUN;
          next_wake_resume = 1'b1;
          next_core_halt = 1'b0;
          next_in_sleep = 1'b0;
          next_in_deep = 1'b0;
          if (state == DSS_DEEP) begin
            next_ctrl_high[DSS_ARM_BIT] = 1'b0;
          end
        end
      end
      default: begin
        next_state = DSS_RUN;
      end
    endcase
  end

  // Revision word on table read of the configuration address.
  // Firmware reads it before choosing the nop-guarded entry sequence;
  // any other address reads back zero, as no other table words exist here.
  always_comb begin
    next_table_data = table_data;
    if (table_rd) begin
      next_table_data = (table_addr == DSS_REVID_ADDR) ?
        {3'h0, (late_rev ? DSS_REV_LATE : DSS_REV_EARLY)} : 8'h00;
    end
  end


  // Register stage: every output of the block comes straight from here,
  // so the core never sees a combinational path from its own strobes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DSS_RUN;
      ctrl_high <= DSS_CTRL_RESET;
      arm_gap <= DSS_ENTRY_CYC;
      guarded <= 1'b0;
      core_halt <= 1'b0;
      in_sleep <= 1'b0;
      in_deep_sleep <= 1'b0;
      wake_resume <= 1'b0;
      wake_lost <= 1'b0;
      table_data <= 8'h00;
    end else begin
      state <= next_state;
      ctrl_high <= next_ctrl_high;
      arm_gap <= next_arm_gap;
      guarded <= next_guarded;
      core_halt <= next_core_halt;
      in_sleep <= next_in_sleep;
      in_deep_sleep <= next_in_deep;
      wake_resume <= next_wake_resume;
      wake_lost <= next_wake_lost;
      table_data <= next_table_data;
    end
  end
endmodule // dss_sequencer

// ===== bench/dss_core_model.sv
/* Core model: retires an arm write, gap nops and a sleep.
   Assumes calls start just after a rising edge. */
`timescale 1ns/1ps
module dss_core_model (
  input wire logic clk,
  output logic op_valid,
  output dss_pkg::dss_op_type op_code,
  output logic [7:0] ctrl_wdata
);
  import dss_pkg::*;
  initial begin
    op_valid = 1'b0;
    op_code = DSS_OP_OTHER;
    ctrl_wdata = 8'h00;
  end
  // One instruction a cycle; released data is inverted so stale values fail
  task automatic run(input logic arm, input int gap);
    for (int i = 0; i <= gap + 1; i++) begin
      op_valid = 1'b1;
      op_code = i == 0 ? DSS_OP_ARM : i > gap ? DSS_OP_SLEEP : DSS_OP_NOP;
      ctrl_wdata = {arm, 7'h00};
      @(posedge clk);
      #1;
    end
    op_valid = 1'b0;
    ctrl_wdata = ~ctrl_wdata;
  endtask
endmodule // dss_core_model

// ===== bench/dss_sequencer_assertions.sv
/* Port checker of the deep sleep sequencer.
   Assumes one instruction retired per cycle. */
`timescale 1ns/1ps
module dss_seq_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic late_rev,
  input wire logic op_valid,
  input wire dss_pkg::dss_op_type op_code,
  input wire logic [7:0] ctrl_wdata,
  input wire logic table_rd,
  input wire logic [21:0] table_addr,
  input wire logic wake_event,
  input wire logic [7:0] table_data,
  input wire logic core_halt,
  input wire logic in_sleep,
  input wire logic in_deep_sleep,
  input wire logic wake_resume,
  input wire logic wake_lost
);
  import dss_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Taken sleep and arming write
  wire slp = op_valid && op_code == DSS_OP_SLEEP && !core_halt;
  wire arm = op_valid && op_code == DSS_OP_ARM && ctrl_wdata[DSS_ARM_BIT];
  halt_on_sleep_a: assert property (slp |=> core_halt) else $error("halt");
  deep_direct_a: assert property (slp && $past(arm) |-> ##[1:6] in_deep_sleep)
    else $error("deep");
  late_gap_a: assert property (slp && late_rev && $past(arm, 2) |->
    ##[1:6] (in_deep_sleep || wake_resume)) else $error("gap");
  conv_sleep_a: assert property (slp && !$past(arm) && !(late_rev && $past(arm, 2)) |->
    ##[1:6] in_sleep) else $error("conv");
  lost_cause_a: assert property (wake_lost |-> $past(wake_event) && $past(core_halt))
    else $error("lost");
  no_loss_a: assert property (slp && late_rev && $past(arm, 2) |=> !wake_lost [*6])
    else $error("loss");
  deep_wake_a: assert property (in_deep_sleep && wake_event |-> ##[1:2] wake_resume)
    else $error("wake");
  rev_read_a: assert property (table_rd && table_addr == DSS_REVID_ADDR |=>
    table_data == {3'h0, late_rev ? DSS_REV_LATE : DSS_REV_EARLY}) else $error("rev");
endmodule // dss_seq_checker
bind dss_sequencer dss_seq_checker chk (.*);

// ===== bench/deep_sleep_entry_sequencer_test.sv
/* Bench of the deep sleep sequencer with a core model.
   Assumes 100 MHz; the revision pin changes only in reset. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module deep_sleep_entry_sequencer_test;
  import dss_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, late_rev = 1'b0, table_rd = 1'b0, wake_event = 1'b0;
  logic op_valid, core_halt, in_sleep, in_deep_sleep, wake_resume, wake_lost, lost, seen;
  logic [21:0] table_addr = DSS_REVID_ADDR;
  logic [7:0] ctrl_wdata, ctrl_high, table_data;
  dss_op_type op_code;
  int miscompares = 0;
  int n_compared = 0;
  dss_sequencer DUT (.*);
  dss_core_model core (.*);
  initial forever #5 clk = ~clk;
  // Wake pulses last one cycle, so they are latched
  always @(posedge clk) begin
    if (!rst_n) begin
      lost <= 1'b0;
      seen <= 1'b0;
    end else begin
      if (wake_lost === 1'b1) lost <= 1'b1;
      if (wake_resume === 1'b1) seen <= 1'b1;
    end
  end
  task automatic tally_and_finish;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset, read revision, arm and sleep, wake in the entry window on hit
  task automatic run(input logic rev, arm, input int gap, input logic hit, d, s, l);
    rst_n = 1'b0;
    late_rev = rev;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    table_rd = 1'b1;
    @(posedge clk);
    #1 table_rd = 1'b0;
    `CHK(table_data, {3'h0, rev ? DSS_REV_LATE : DSS_REV_EARLY})
    core.run(arm, gap);
    @(posedge clk);
    #1 wake_event = hit;
    @(posedge clk);
    #1 wake_event = 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK(lost, l)
    `CHK({in_deep_sleep, in_sleep}, {d, s})
    `CHK(core_halt, d | s)
    wake_event = !seen;
    @(posedge clk);
    #1 wake_event = 1'b0;
    for (int i = 0; i < 8 && seen !== 1'b1; i++) @(posedge clk);
    #1 `CHK(seen, 1'b1)
    `CHK(core_halt, 1'b0)
    `CHK(ctrl_high[DSS_ARM_BIT], arm && !d)
    if (seen !== 1'b1) tally_and_finish();
  endtask
  initial begin
    @(posedge clk);
    #1 run(1'b0, 1'b1, 0, 1'b0, 1'b1, 1'b0, 1'b0);
    run(1'b0, 1'b1, 1, 1'b0, 1'b0, 1'b1, 1'b0);
    run(1'b1, 1'b1, 1, 1'b0, 1'b1, 1'b0, 1'b0);
    run(1'b1, 1'b1, 1, 1'b1, 1'b0, 1'b0, 1'b0);
    run(1'b1, 1'b1, 0, 1'b1, 1'b1, 1'b0, 1'b1);
    run(1'b1, 1'b0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule // deep_sleep_entry_sequencer_test
